// ==== design/vdc_dac_input.sv ====
// Purpose: Input registers and current-switch decode of the video DAC.
// Assumes: Sample clock is a pin; data and controls come from same-clock logic.
// Notes:   Levels are counted in data LSB steps, OUT+ side.
//
// How it works
// [R1] Select low: capture all inputs on sample rise
// [R2] Select high: output follows inputs, no capture
// [R3] Source holds pass-through select static
// [R4] Six MSBs become 63-segment thermometer code
// [R5] Two LSBs drive two binary-weighted switches; the third switch stays off
// [R6] Coarse plus fine give 256 levels
// [R7] Each control adds its own weighted current
// [R8] Controls captured exactly like data bits
// [R9] Source meets setup and hold around rise
// [R10] Pass-through needs only minimum pulse widths
// [R11] Sync gives sync tip, ignores everything else
// [R12] Blank gives blanking level over lower inputs
// [R13] Force white gives full white, ignores data
// [R14] Highlight adds a tenth of full scale
// [R15] Complementary outputs always sum to sync tip
// [R16] Unconnected inputs read as logic low
// [R17] Source supplies the sample clock
// [R18] Priority: sync, blank, white or data, highlight

`timescale 1ns/10ps
`default_nettype none

module vdc_dac_input (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            nrst,
  // Pins from the pixel source
  vdc_if.dac                                   pins,
  // Current switch settings
  output logic [vdc_pkg::SEG_N-1:0]            coarse_enable,
  output logic [vdc_pkg::SW_N-1:0]             fine_switch,
  output logic [vdc_pkg::CTRL_N-1:0]           control_switch,
  // Output levels
  output logic [vdc_pkg::LVL_W-1:0]            out_pos_level,
  output logic [vdc_pkg::LVL_W-1:0]            out_neg_level,
  output vdc_pkg::vdc_level_e                  level_kind,
  // Status
  output logic                                 passthrough_active,
  output logic                                 sample_taken
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]                            clk_sync;
    logic                                  clk_stable;
    logic [vdc_pkg::DATA_W-1:0]            held_code;
    logic [vdc_pkg::CTRL_N-1:0]            held_ctrl;
    logic [vdc_pkg::SEG_N-1:0]             coarse;
    logic [vdc_pkg::SW_N-1:0]              fine;
    logic [vdc_pkg::CTRL_N-1:0]            ctrl;
    logic [vdc_pkg::LVL_W-1:0]             pos;
    logic [vdc_pkg::LVL_W-1:0]             neg;
    vdc_pkg::vdc_level_e                   kind;
    logic                                  passthrough;
    logic                                  taken;
  } vdc_state_s;

  vdc_state_s state;
  vdc_state_s next_state;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic [vdc_pkg::SEG_N-1:0] thermometer(
    input logic [vdc_pkg::COARSE_W-1:0] msbs
  );
    logic [vdc_pkg::SEG_N-1:0] t;
    t = '0;
    for (int i = 0; i < vdc_pkg::SEG_N; i++) begin
      t[i] = (int'(msbs) > i);
    end
    return t;
  endfunction

  // Level from the switches themselves, so a decode slip shows up
  function automatic logic [vdc_pkg::LVL_W-1:0] switch_sum(
    input logic [vdc_pkg::SEG_N-1:0] seg,
    input logic [vdc_pkg::SW_N-1:0]  sw
  );
    logic [vdc_pkg::LVL_W-1:0] s;
    s = '0;
    for (int i = 0; i < vdc_pkg::SEG_N; i++) begin
      if (seg[i]) begin
        s = s + vdc_pkg::SEG_WEIGHT;
      end
    end
    if (sw[0]) begin
      s = s + vdc_pkg::FINE_WT0;
    end
    if (sw[1]) begin
      s = s + vdc_pkg::FINE_WT1;
    end
    if (sw[2]) begin
      s = s + vdc_pkg::FINE_WT2;
    end
    return s;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  logic [vdc_pkg::DATA_W-1:0]      src_code;
  logic [vdc_pkg::CTRL_N-1:0]      src_ctrl;
  logic [vdc_pkg::DATA_W-1:0]      eff_code;
  logic                            rise;
  logic [vdc_pkg::LVL_W-1:0]       video;

  always_comb begin
    next_state = state;
    // Sample clock is a pin: three stages, change once stages 2 and 3 agree
    // Capture lands four clocks after the pin rise: the high phase needs four, the low phase two
    next_state.clk_sync = {state.clk_sync[1:0], pins.sample_clock};
    if (state.clk_sync[1] == state.clk_sync[2]) begin
      next_state.clk_stable = state.clk_sync[2];
    end
    rise = (state.clk_sync[1] == state.clk_sync[2]) && state.clk_sync[2]
           && !state.clk_stable;
    next_state.taken = 1'b0;
    // Select read directly each cycle; source keeps it static [R3]
    next_state.passthrough = pins.passthrough_select;
    // Data and controls: pins resolve low when released [R16]
    if (!pins.passthrough_select && rise) begin
      next_state.held_code = pins.pixel_code;   // [R1]
      next_state.held_ctrl = pins.control;      // [R8]
      next_state.taken     = 1'b1;
    end
    // Pass-through takes the pins, not the held copy [R2] [R10]
    if (pins.passthrough_select) begin
      src_code = pins.pixel_code;
      src_ctrl = pins.control;
    end else begin
      src_code = next_state.held_code;          // [R9]
      src_ctrl = next_state.held_ctrl;
    end
    // Force white ignores the data bits [R13]
    if (src_ctrl[vdc_pkg::CTL_WHITE]) begin
      eff_code = vdc_pkg::CODE_WHITE;
    end else begin
      eff_code = src_code;
    end
    next_state.coarse = thermometer(eff_code[vdc_pkg::DATA_W-1:vdc_pkg::FINE_W]); // [R4]
    next_state.fine   = {1'b0, eff_code[1], eff_code[0]};                           // [R5]
    next_state.ctrl   = src_ctrl;                                                   // [R7]
    // Coarse and fine summed on the black pedestal [R6]
    video = vdc_pkg::LVL_BLACK + switch_sum(next_state.coarse, next_state.fine);
    if (src_ctrl[vdc_pkg::CTL_BOOST]) begin
      video = video + vdc_pkg::LVL_BOOST;       // [R14]
    end
    // Fixed priority among the controls [R18]
    if (src_ctrl[vdc_pkg::CTL_SYNC]) begin
      next_state.pos  = vdc_pkg::LVL_ZERO;      // [R11]
      next_state.kind = vdc_pkg::VDC_LVL_SYNC;
    end else if (src_ctrl[vdc_pkg::CTL_BLANK]) begin
      next_state.pos  = vdc_pkg::LVL_BLANK;     // [R12]
      next_state.kind = vdc_pkg::VDC_LVL_BLANK;
    end else begin
      next_state.pos  = video;
      next_state.kind = vdc_pkg::VDC_LVL_VIDEO;
    end
    // Complementary output takes the rest of the sync-tip current [R15]
    next_state.neg = vdc_pkg::LVL_FULL - next_state.pos;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '{
        clk_sync:    3'h0,
        clk_stable:  1'b0,
        held_code:   8'h00,
        held_ctrl:   4'h0,
        coarse:      '0,
        fine:        3'h0,
        ctrl:        4'h0,
        pos:         vdc_pkg::LVL_ZERO,
        neg:         vdc_pkg::LVL_FULL,
        kind:        vdc_pkg::VDC_LVL_SYNC,
        passthrough: 1'b0,
        taken:       1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign coarse_enable      = state.coarse;
  assign fine_switch        = state.fine;
  assign control_switch     = state.ctrl;
  assign out_pos_level      = state.pos;
  assign out_neg_level      = state.neg;
  assign level_kind         = state.kind;
  assign passthrough_active = state.passthrough;
  assign sample_taken       = state.taken;

endmodule

`default_nettype wire

// ==== design/vdc_pkg.sv ====
// Purpose: Shared constants and types for the video DAC input control.
// Assumes: Levels are counted in data LSB steps of the output current.
// Notes:   OUT+ level plus OUT- level always equals the sync-tip total.

package vdc_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned COARSE_W = 6;
  localparam int unsigned FINE_W   = 2;
  localparam int unsigned SEG_N    = 63;
  localparam int unsigned SW_N     = 3;
  localparam int unsigned LVL_W    = 9;
  localparam int unsigned CTRL_N   = 4;

  // ************************************************************
  // Output levels, OUT+ side, in data LSB steps
  // ************************************************************
  // Sync tip total current, split between the two outputs
  localparam logic [8:0] LVL_FULL   = 9'h1a2;
  // Blanking level above the sync tip
  localparam logic [8:0] LVL_BLANK  = 9'h071;
  // Black pedestal above the sync tip
  localparam logic [8:0] LVL_BLACK  = 9'h086;
  // Highlight boost, one tenth of full scale
  localparam logic [8:0] LVL_BOOST  = 9'h01d;
  localparam logic [8:0] LVL_ZERO   = 9'h000;
  // Weight of one coarse segment
  localparam logic [8:0] SEG_WEIGHT = 9'h004;
  // Fine switch weights: bit 0, bit 1, spare
  localparam logic [8:0] FINE_WT0   = 9'h001;
  localparam logic [8:0] FINE_WT1   = 9'h002;
  localparam logic [8:0] FINE_WT2   = 9'h001;

  // ************************************************************
  // Control bit positions
  // ************************************************************
  localparam int unsigned CTL_SYNC  = 3;
  localparam int unsigned CTL_BLANK = 2;
  localparam int unsigned CTL_WHITE = 1;
  localparam int unsigned CTL_BOOST = 0;

  localparam logic [7:0] CODE_WHITE = 8'hff;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLOCK_MHZ     = 10;
  // Half period of the generated sample clock, in clock cycles
  localparam int unsigned HALF_PERIOD   = 4;

  typedef enum logic [1:0] {
    VDC_LVL_SYNC  = 2'b00,
    VDC_LVL_BLANK = 2'b01,
    VDC_LVL_VIDEO = 2'b10
  } vdc_level_e;

endpackage

// ==== design/vdc_if.sv ====
// Purpose: Pins between the pixel source and the video DAC input logic.
// Assumes: One common clock for both ends.
// Notes:   Undriven data and control pins resolve low, like pull-downs.

`timescale 1ns/10ps
`default_nettype none

interface vdc_if;

  // Driven by the source
  logic                             sample_clock;
  logic                             passthrough_select;
  logic [vdc_pkg::DATA_W-1:0]       pixel_code_drv;
  logic [vdc_pkg::CTRL_N-1:0]       control_drv;
  logic                             pins_oe_n;

  // Resolved pin levels seen by the DAC
  logic [vdc_pkg::DATA_W-1:0]       pixel_code;
  logic [vdc_pkg::CTRL_N-1:0]       control;

  // Released pins are pulled low
  assign pixel_code = pins_oe_n ? '0 : pixel_code_drv;
  assign control    = pins_oe_n ? '0 : control_drv;

  modport source (
    output sample_clock,
    output passthrough_select,
    output pixel_code_drv,
    output control_drv,
    output pins_oe_n
  );

  modport dac (
    input  sample_clock,
    input  passthrough_select,
    input  pixel_code,
    input  control
  );

endinterface

`default_nettype wire

// ==== design/vdc_pixel_source.sv ====
// Purpose: Pixel source end: makes the sample clock and drives the pins.
// Assumes: User values are sampled once per sample period, except the pass-through mode, which is sampled every clock.
// Notes:   Data, control and enable pins change on the falling sample edge, far from the rise.

`timescale 1ns/10ps
`default_nettype none

module vdc_pixel_source #(
  parameter int unsigned HALF_PERIOD = vdc_pkg::HALF_PERIOD
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // User side
  input  wire logic                       mode_passthrough,
  input  wire logic                       drive_enable,
  input  wire logic [vdc_pkg::DATA_W-1:0] pixel,
  input  wire logic                       sync_force,
  input  wire logic                       blank_force,
  input  wire logic                       full_white_force,
  input  wire logic                       highlight_boost,
  output logic                            pixel_taken,
  // Pins
  vdc_if.source                           pins
);

  typedef struct packed {
    logic [15:0]                  count;
    logic                         sclk;
    logic [vdc_pkg::DATA_W-1:0]   code;
    logic [vdc_pkg::CTRL_N-1:0]   ctrl;
    logic                         oe_n;
    logic                         mode;
    logic                         taken;
  } vdc_src_state_s;

  vdc_src_state_s state;
  vdc_src_state_s next_state;

  always_comb begin
    next_state       = state;
    next_state.taken = 1'b0;
    // Select changes only with the user's static setting [R3]
    next_state.mode  = mode_passthrough;
    if (state.count == 16'(HALF_PERIOD - 1)) begin
      next_state.count = 16'h0000;
      // Divided clock from our own clock [R17]
      next_state.sclk  = !state.sclk;
      if (state.sclk) begin
        // Update on the fall, half a period before the next rise [R9]
        next_state.code  = pixel;
        next_state.ctrl  = {sync_force, blank_force, full_white_force, highlight_boost};
        next_state.oe_n  = !drive_enable;
        next_state.taken = 1'b1;
      end
    end else begin
      next_state.count = state.count + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '{
        count: 16'h0000,
        sclk:  1'b0,
        code:  8'h00,
        ctrl:  4'h0,
        oe_n:  1'b1,
        mode:  1'b0,
        taken: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  assign pins.sample_clock       = state.sclk;
  assign pins.passthrough_select = state.mode;
  assign pins.pixel_code_drv     = state.code;
  assign pins.control_drv        = state.ctrl;
  assign pins.pins_oe_n          = state.oe_n;
  assign pixel_taken             = state.taken;

endmodule

`default_nettype wire

// ==== testbench/vdc_tb_asserts.sv ====
// Purpose: Assertions on the DAC pins and decode outputs.
// Assumes: Both ends share one clock.
// Notes:   Levels in data LSB steps, OUT+ side.
`timescale 1ns/10ps
`default_nettype none
module vdc_tb_asserts (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                nrst,
  // Pins
  input  wire logic                sample_clock,
  input  wire logic                passthrough_select,
  input  wire logic [7:0]          pixel_code,
  input  wire logic [3:0]          control,
  // Decode outputs
  input  wire logic [62:0]         coarse_enable,
  input  wire logic [2:0]          fine_switch,
  input  wire logic [3:0]          control_switch,
  input  wire logic [8:0]          out_pos_level,
  input  wire logic [8:0]          out_neg_level,
  input  wire vdc_pkg::vdc_level_e level_kind,
  input  wire logic                passthrough_active,
  input  wire logic                sample_taken
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [1:0] reg_age;
  logic [8:0] vid;
  // ************************************************************
  // Helpers
  // ************************************************************
  // Leaving pass-through may reload held values, so wait it out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      reg_age <= 2'h0;
    else if (passthrough_select || passthrough_active)
      reg_age <= 2'h0;
    else if (reg_age != 2'h3)
      reg_age <= reg_age + 2'h1;
  end
  assign vid = 9'h086 + 9'($countones(coarse_enable)) * 9'h004 + {8'h00, fine_switch[0]}
             + {7'h00, fine_switch[1], 1'b0} + (control_switch[0] ? 9'h01d : 9'h000);
  // ************************************************************
  // Properties
  // ************************************************************
  sequence s_rise_reg;
    $rose(sample_clock) && !passthrough_select;
  endsequence
  sequence s_capture;
    ##4 sample_taken;
  endsequence
  chk_rise_capture: assert property (s_rise_reg |-> s_capture)
    else $error("no capture after sample clock rise");
  chk_pt_no_capture: assert property (
    passthrough_select && $past(passthrough_select, 4) |-> !sample_taken)
    else $error("capture seen in pass-through");
  chk_pt_follow: assert property (
    passthrough_select && $past(passthrough_select) |=>
    control_switch == $past(control) && fine_switch[1:0] == $past(pixel_code[1:0]))
    else $error("pass-through output does not follow pins");
  chk_capture_content: assert property (
    sample_taken && !passthrough_active |-> control_switch == $past(control)
    && (control_switch[1] ? fine_switch[1:0] == 2'h3 && $countones(coarse_enable) == 63
        : fine_switch[1:0] == $past(pixel_code[1:0])
          && $countones(coarse_enable) == $past(pixel_code[7:2])))
    else $error("captured value differs from pins");
  chk_out_sum: assert property (
    {1'b0, out_pos_level} + {1'b0, out_neg_level} == 10'h1a2)
    else $error("complementary outputs do not sum to sync tip");
  chk_sync_tip: assert property (
    control_switch[3] |-> out_pos_level == 9'h000 && level_kind == vdc_pkg::VDC_LVL_SYNC)
    else $error("sync level wrong");
  chk_blank_level: assert property (
    control_switch[3:2] == 2'b01 |->
    out_pos_level == 9'h071 && level_kind == vdc_pkg::VDC_LVL_BLANK)
    else $error("blank level wrong");
  chk_white_level: assert property (
    control_switch[3:1] == 3'b001 |->
    out_pos_level == (control_switch[0] ? 9'h1a2 : 9'h185))
    else $error("force white level wrong");
  chk_video_level: assert property (
    control_switch[3:1] == 3'b000 && $past(nrst) |-> out_pos_level == vid)
    else $error("video level wrong");
  chk_hold_between: assert property (
    reg_age == 2'h3 && !sample_taken |->
    $stable(out_pos_level) && $stable(control_switch))
    else $error("output changed without capture");
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: Pixel source driving the DAC input logic, self-checked.
// Assumes: Same clock at both ends; HALF_PERIOD at 4, the least the DAC takes.
// Notes:   Expected levels from the level table in LSB steps.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        mode_pt = 1'b0;
  logic        drive_en = 1'b0;
  logic [7:0]  pixel = 8'h00;
  logic [3:0]  ctl = 4'h0;
  logic        pixel_taken;
  logic [62:0] coarse;
  logic [2:0]  fine;
  logic [3:0]  cswitch;
  logic [8:0]  pos;
  logic [8:0]  neg;
  logic        pt_active;
  logic        sample_taken;
  logic [8:0]  last_exp = 9'h086;
  vdc_pkg::vdc_level_e kind;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  vdc_if pins_if ();
  vdc_pixel_source #(.HALF_PERIOD(4)) i_vdc_pixel_source (.clock(clock), .nrst(nrst),
    .mode_passthrough(mode_pt), .drive_enable(drive_en), .pixel(pixel),
    .sync_force(ctl[3]), .blank_force(ctl[2]), .full_white_force(ctl[1]),
    .highlight_boost(ctl[0]), .pixel_taken(pixel_taken), .pins(pins_if));
  vdc_dac_input i_vdc_dac_input (.clock(clock), .nrst(nrst), .pins(pins_if),
    .coarse_enable(coarse), .fine_switch(fine), .control_switch(cswitch),
    .out_pos_level(pos), .out_neg_level(neg), .level_kind(kind),
    .passthrough_active(pt_active), .sample_taken(sample_taken));
  vdc_tb_asserts i_asserts (.clock(clock), .nrst(nrst),
    .sample_clock(pins_if.sample_clock), .passthrough_select(pins_if.passthrough_select),
    .pixel_code(pins_if.pixel_code), .control(pins_if.control), .coarse_enable(coarse),
    .fine_switch(fine), .control_switch(cswitch), .out_pos_level(pos), .out_neg_level(neg),
    .level_kind(kind), .passthrough_active(pt_active), .sample_taken(sample_taken));
  always #50 clock = ~clock;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      test_done();
    end
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [8:0] level(input logic [3:0] c, input logic [7:0] d);
    logic [8:0] v;
    v = c[1] ? 9'h185 : 9'h086 + {1'b0, d};
    if (c[3])
      v = 9'h000;
    else if (c[2])
      v = 9'h071;
    else if (c[0])
      v = v + 9'h01d;
    return v;
  endfunction
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wait_pix;
    do @(posedge clock) #1; while (pixel_taken !== 1'b1);
  endtask
  task automatic apply(input logic [3:0] c, input logic [7:0] d, input logic en);
    vdc_pkg::vdc_level_e exp_kind;
    wait_pix();
    ctl = c;
    pixel = d;
    drive_en = en;
    wait_pix();
    check("held level", last_exp, pos);
    do @(posedge clock) #1; while (sample_taken !== 1'b1);
    last_exp = en ? level(c, d) : 9'h086;
    check("out plus", last_exp, pos);
    check("out minus", 9'h1a2 - last_exp, neg);
    check("controls", {5'h00, en ? c : 4'h0}, {5'h00, cswitch});
    exp_kind = vdc_pkg::VDC_LVL_VIDEO;
    if (en && c[3])
      exp_kind = vdc_pkg::VDC_LVL_SYNC;
    else if (en && c[2])
      exp_kind = vdc_pkg::VDC_LVL_BLANK;
    check("kind", {7'h00, exp_kind}, {7'h00, kind});
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_priority;
    apply(4'hf, 8'h5a, 1'b1);
    apply(4'h7, 8'hff, 1'b1);
    apply(4'h3, 8'h00, 1'b1);
    apply(4'h2, 8'h33, 1'b1);
    apply(4'h1, 8'h00, 1'b1);
    apply(4'h1, 8'hff, 1'b1);
  endtask
  task automatic t_data;
    logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'hfc, 8'hff};
    foreach (codes[i]) apply(4'h0, codes[i], 1'b1);
    check("fine", 9'h003, {6'h00, fine});
    check("segments", 9'h03f, 9'($countones(coarse)));
  endtask
  task automatic t_pulldown;
    apply(4'h5, 8'h77, 1'b0);
  endtask
  task automatic t_passthrough;
    // Select only moves between scenarios, never mid-frame
    mode_pt = 1'b1;
    // Pins left released by the pull-down case must drive again
    drive_en = 1'b1;
    wait_pix();
    wait_pix();
    for (int n = 0; n < 2; n++) begin
      ctl = n ? 4'h4 : 4'h1;
      pixel = 8'h40;
      wait_pix();
      @(posedge clock) #1;
      check("follow", level(ctl, 8'h40), pos);
      check("pt flag", 9'h001, {8'h00, pt_active});
      repeat (6) @(posedge clock) #1 check("no capture", 9'h000, {8'h00, sample_taken});
    end
    mode_pt = 1'b0;
    do @(posedge clock) #1; while (sample_taken !== 1'b1);
    last_exp = 9'h071;
    check("back to registered", last_exp, pos);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    t_priority();
    t_data();
    t_pulldown();
    t_passthrough();
    t_priority();
    test_done();
  end
endmodule
`default_nettype wire
